// ===== bench/spsc_port_partner.sv
`timescale 1ns/100ps
// ********************
// type-c port partner on cc, with pd messages
// ********************
module spsc_port_partner (
    input wire logic clk_sys, // system clock
    output logic attached, // partner present on cc
    output logic role_source, // local role, 1 source
    output logic cc_change_evt, // cc status change pulse
    output logic pd_msg_evt // incoming pd message pulse
);
    initial
    begin
        attached = 1'b0;
        role_source = 1'b0;
        cc_change_evt = 1'b0;
        pd_msg_evt = 1'b0;
    end
    // attach or detach, one cc change pulse with it
    task automatic plug(input logic on, input logic src);
        @(posedge clk_sys);
        #1;
        attached = on;
        role_source = src;
        cc_change_evt = 1'b1;
        @(posedge clk_sys);
        #1;
        cc_change_evt = 1'b0;
    endtask
    // one pd message, one cycle long
    task automatic send_msg();
        @(posedge clk_sys);
        #1;
        pd_msg_evt = 1'b1;
        @(posedge clk_sys);
        #1;
        pd_msg_evt = 1'b0;
    endtask
endmodule

// ===== bench/spsc_top_tb_top.sv
`timescale 1ns/100ps
module spsc_top_tb_top;
    import spsc_pkg::*;
    logic clk_sys, rst, eeprom_present, eeprom_done, host_cfg_done, gpio_evt, i2c_evt;
    logic volt_alert, fault_alert, standby_req, die_hot, die_cool, path_auto_resume;
    logic fw_path_reenable, attached, role_source, cc_change_evt, pd_msg_evt;
    logic policy_hv_negotiate, policy_safe, eeprom_load_req, cfg_loaded, application_mode;
    logic pd_phy_en, modern_standby, cc_monitor_en, source_5v_path, sink_hv_path;
    logic sink_ext_path_ctrl, cable_power_path, die_shutdown, path_shutdown, hv;
    logic [2:0] strap_in_a, strap_in_b;
    logic [1:0] path_hot, path_cool, addr_index, ix;
    logic [3:0] evt4;
    logic [6:0] i2c_target_addr;
    logic [15:0] idle_timeout, contract_vmax_mv;
    spsc_pwr_type power_state;
    int n_fail = 0;
    int comparisons = 0;
    logic [2:0] tab_a [9] = '{3'h7, 3'h3, 3'h4, 3'h3, 3'h7, 3'h0, 3'h6, 3'h5, 3'h1};
    logic [2:0] tab_b [9] = '{3'h3, 3'h3, 3'h0, 3'h7, 3'h0, 3'h0, 3'h0, 3'h7, 3'h1};
    assign {fault_alert, volt_alert, i2c_evt, gpio_evt} = evt4;

    spsc_port_partner u_partner (.clk_sys(clk_sys), .attached(attached),
        .role_source(role_source), .cc_change_evt(cc_change_evt), .pd_msg_evt(pd_msg_evt));

    spsc_top u_dut (.clk_sys(clk_sys), .rst(rst), .strap_in_a(strap_in_a),
        .strap_in_b(strap_in_b), .eeprom_present(eeprom_present), .eeprom_done(eeprom_done),
        .host_cfg_done(host_cfg_done), .pd_msg_evt(pd_msg_evt), .cc_change_evt(cc_change_evt),
        .gpio_evt(gpio_evt), .i2c_evt(i2c_evt), .volt_alert(volt_alert),
        .fault_alert(fault_alert), .attached(attached), .role_source(role_source),
        .standby_req(standby_req), .idle_timeout(idle_timeout), .die_hot(die_hot),
        .die_cool(die_cool), .path_hot(path_hot), .path_cool(path_cool),
        .path_auto_resume(path_auto_resume), .fw_path_reenable(fw_path_reenable),
        .policy_hv_negotiate(policy_hv_negotiate), .policy_safe(policy_safe),
        .addr_index(addr_index), .i2c_target_addr(i2c_target_addr),
        .eeprom_load_req(eeprom_load_req), .cfg_loaded(cfg_loaded),
        .application_mode(application_mode), .pd_phy_en(pd_phy_en),
        .contract_vmax_mv(contract_vmax_mv), .power_state(power_state),
        .modern_standby(modern_standby), .cc_monitor_en(cc_monitor_en),
        .source_5v_path(source_5v_path), .sink_hv_path(sink_hv_path),
        .sink_ext_path_ctrl(sink_ext_path_ctrl), .cable_power_path(cable_power_path),
        .die_shutdown(die_shutdown), .path_shutdown(path_shutdown));

    // ********************
    // clock, helpers, verdict
    // ********************
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic do_reset(input logic [2:0] a, input logic [2:0] b, input int n);
        rst = 1'b1;
        strap_in_a = a;
        strap_in_b = b;
        tick(n);
        rst = 1'b0;
    endtask
    task automatic pulse_evt(input int k);
        evt4[k] = 1'b1;
        tick(1);
        evt4[k] = 1'b0;
    endtask
    task automatic close_out();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        #200000;
        n_fail++;
        close_out();
    end

    // ********************
    // test sequence
    // ********************
    initial
    begin
        {eeprom_present, eeprom_done, host_cfg_done, standby_req, die_hot} = 5'h00;
        {die_cool, path_auto_resume, fw_path_reenable, path_hot, path_cool} = 7'h00;
        evt4 = 4'h0;
        idle_timeout = 16'h0004;
        do_reset(3'h7, 3'h3, 20);
        chk(i2c_target_addr, 7'h20, "reset addr");
        chk(power_state, SPSC_PWR_ACTIVE, "reset state");
        for (int i = 0; i < 9; i++)
        begin
            do_reset(tab_a[i], tab_b[i], 2);
            tick(5);
            hv = (i < 4);
            ix = (i < 8) ? i[1:0] : 2'h0;
            chk(policy_hv_negotiate, hv, "hv policy");
            chk(policy_safe, !hv, "safe policy");
            chk(addr_index, ix, "addr index");
            chk(i2c_target_addr, 7'h20 + ix, "target addr");
            chk(application_mode, hv, "app mode");
            chk(pd_phy_en, hv, "pd phy");
            chk(contract_vmax_mv, hv ? 16'h4e20 : 16'h0000, "vmax");
        end
        // config load with the safe policy, eeprom first, then host
        eeprom_present = 1'b1;
        do_reset(3'h0, 3'h0, 2);
        tick(3);
        chk(eeprom_load_req, 1'b1, "eeprom req");
        chk(pd_phy_en, 1'b0, "pd before cfg");
        eeprom_done = 1'b1;
        tick(1);
        eeprom_done = 1'b0;
        tick(3);
        chk(cfg_loaded, 1'b1, "eeprom cfg");
        chk(pd_phy_en, 1'b1, "pd after cfg");
        eeprom_present = 1'b0;
        do_reset(3'h7, 3'h0, 2);
        u_partner.plug(1'b1, 1'b0);
        tick(4);
        chk(sink_hv_path, 1'b0, "safe sink off");
        host_cfg_done = 1'b1;
        tick(1);
        host_cfg_done = 1'b0;
        tick(4);
        chk(cfg_loaded, 1'b1, "host cfg");
        chk({sink_hv_path, sink_ext_path_ctrl}, 2'h3, "sink after cfg");
        // hv policy, sink during implicit contract
        do_reset(3'h3, 3'h7, 2);
        tick(4);
        chk({sink_hv_path, source_5v_path}, 2'h2, "hv sink on");
        u_partner.send_msg();
        tick(3);
        chk(power_state, SPSC_PWR_ACTIVE, "still active");
        tick(3);
        chk(power_state, SPSC_PWR_IDLE, "idle");
        chk({sink_hv_path, cable_power_path}, 2'h3, "idle sink");
        for (int k = 0; k < 4; k++)
        begin
            pulse_evt(k);
            tick(1);
            chk(power_state, SPSC_PWR_ACTIVE, "wake");
            tick(6);
            chk(power_state, SPSC_PWR_IDLE, "re-idle");
        end
        standby_req = 1'b1;
        tick(3);
        chk({modern_standby, sink_hv_path, cable_power_path}, 3'h4, "stby sink");
        u_partner.send_msg();
        tick(1);
        chk(power_state, SPSC_PWR_ACTIVE, "msg wake");
        standby_req = 1'b0;
        u_partner.plug(1'b0, 1'b0);
        tick(15);
        chk(power_state, SPSC_PWR_SLEEP, "sleep");
        chk(cc_monitor_en, 1'b1, "cc watch");
        chk({source_5v_path, sink_hv_path, cable_power_path}, 3'h0, "sleep paths");
        u_partner.plug(1'b1, 1'b1);
        tick(3);
        chk(power_state, SPSC_PWR_ACTIVE, "attach wake");
        chk({source_5v_path, sink_hv_path, cable_power_path}, 3'h5, "src paths");
        tick(8);
        standby_req = 1'b1;
        tick(3);
        chk({modern_standby, source_5v_path, cable_power_path}, 3'h6, "stby src");
        standby_req = 1'b0;
        // thermal handling
        die_hot = 1'b1;
        tick(3);
        chk({die_shutdown, cc_monitor_en, pd_phy_en, source_5v_path, cable_power_path}, 5'h10, "die");
        die_hot = 1'b0;
        tick(3);
        chk(die_shutdown, 1'b1, "die held");
        die_cool = 1'b1;
        tick(3);
        chk({die_shutdown, source_5v_path}, 2'h1, "die clear");
        die_cool = 1'b0;
        path_cool = 2'h3;
        path_hot = 2'h2;
        tick(3);
        chk({path_shutdown, source_5v_path, cable_power_path}, 3'h4, "path trip");
        path_hot = 2'h0;
        tick(4);
        chk(path_shutdown, 1'b1, "path held");
        fw_path_reenable = 1'b1;
        tick(1);
        fw_path_reenable = 1'b0;
        tick(3);
        chk({path_shutdown, source_5v_path}, 2'h1, "fw resume");
        path_hot = 2'h1;
        tick(3);
        chk(path_shutdown, 1'b1, "path trip b");
        path_hot = 2'h0;
        path_auto_resume = 1'b1;
        tick(4);
        chk({path_shutdown, cable_power_path}, 2'h1, "auto resume");
        close_out();
    end
endmodule

// ===== hw/spsc_cfg.svh
`ifndef SPSC_CFG_SVH
`define SPSC_CFG_SVH
// strap pairs (a,b), high-voltage negotiation policy, index #1..#4
`define SPSC_HV1_A 3'h7
`define SPSC_HV1_B 3'h3
`define SPSC_HV2_A 3'h3
`define SPSC_HV2_B 3'h3
`define SPSC_HV3_A 3'h4
`define SPSC_HV3_B 3'h0
`define SPSC_HV4_A 3'h3
`define SPSC_HV4_B 3'h7
// strap pairs (a,b), safe policy, index #1..#4
`define SPSC_SF1_A 3'h7
`define SPSC_SF1_B 3'h0
`define SPSC_SF2_A 3'h0
`define SPSC_SF2_B 3'h0
`define SPSC_SF3_A 3'h6
`define SPSC_SF3_B 3'h0
`define SPSC_SF4_A 3'h5
`define SPSC_SF4_B 3'h7
// address index codes and target address base
`define SPSC_IDX1 2'h0
`define SPSC_IDX2 2'h1
`define SPSC_IDX3 2'h2
`define SPSC_IDX4 2'h3
`define SPSC_ADDR_BASE 7'h20
// contract voltage cap in millivolts
`define SPSC_VMAX_MV 16'h4e20
// zero for reset of the idle timer and outputs, one for the idle timer step
`define SPSC_CNT_ZERO 16'h0000
`define SPSC_CNT_ONE 16'h0001
`endif

// ===== hw/spsc_pkg.sv
package spsc_pkg;
    typedef enum logic [1:0] {SPSC_BOOT_STRAP, SPSC_BOOT_EEPROM, SPSC_BOOT_HOST,
        SPSC_BOOT_RUN} spsc_boot_type;
    typedef enum logic [1:0] {SPSC_PWR_ACTIVE, SPSC_PWR_IDLE,
        SPSC_PWR_SLEEP} spsc_pwr_type;
endpackage

// ===== hw/spsc_top.sv
`timescale 1ns/100ps
`include "spsc_cfg.svh"

// Summary of operation
// - hv strap pairs select hv policy, index 1-4
// - hv policy enables sink during implicit contract
// - hv policy: application mode, PD on, 20V cap
// - safe strap pairs select safe policy, sink off until config loaded
// - safe policy: PD off until config loaded
// - exactly one of Active, Idle, Sleep, autonomously
// - CC monitoring stays on in Sleep
// - Active to Idle only after quiet period
// - path enables per state and role
// - modern standby: cable off, sink off
// - die overtemp disables all but supervisor
// - die shutdown clears below hysteresis point
// - path overtemp disables source path and cable
// - path recovery automatic or firmware re-enable
// - boot: straps, then eeprom, else host
// - index 1-4 gives address 0x20-0x23
module spsc_top (
    input wire logic clk_sys, // system clock
    input wire logic rst, // sync reset, active high
    input wire logic [2:0] strap_in_a, // decoded strap a
    input wire logic [2:0] strap_in_b, // decoded strap b
    input wire logic eeprom_present, // eeprom answered
    input wire logic eeprom_done, // eeprom load finished
    input wire logic host_cfg_done, // host load finished
    input wire logic pd_msg_evt, // incoming PD message
    input wire logic cc_change_evt, // CC status change
    input wire logic gpio_evt, // GPIO input event
    input wire logic i2c_evt, // I2C transaction
    input wire logic volt_alert, // voltage alert
    input wire logic fault_alert, // fault alert
    input wire logic attached, // Type-C partner attached
    input wire logic role_source, // 1 source, 0 sink
    input wire logic standby_req, // modern standby wanted
    input wire logic [15:0] idle_timeout, // quiet cycles before Idle
    input wire logic die_hot, // die above shutdown threshold
    input wire logic die_cool, // die below threshold minus hysteresis
    input wire logic [1:0] path_hot, // path above its threshold
    input wire logic [1:0] path_cool, // path cooled by hysteresis
    input wire logic path_auto_resume, // 1 resume by itself
    input wire logic fw_path_reenable, // firmware re-enable pulse
    output logic policy_hv_negotiate, // hv negotiation policy
    output logic policy_safe, // safe policy
    output logic [1:0] addr_index, // address index minus one
    output logic [6:0] i2c_target_addr, // 7-bit target address
    output logic eeprom_load_req, // trying eeprom
    output logic cfg_loaded, // configuration present
    output logic application_mode, // application mode
    output logic pd_phy_en, // PD physical layer on
    output logic [15:0] contract_vmax_mv, // contract voltage cap
    output spsc_pkg::spsc_pwr_type power_state, // current power state
    output logic modern_standby, // modern standby variant
    output logic cc_monitor_en, // CC detection running
    output logic source_5v_path, // 5V source path enable
    output logic sink_hv_path, // hv sink path enable
    output logic sink_ext_path_ctrl, // external sink path enable
    output logic cable_power_path, // cable power enable
    output logic die_shutdown, // central shutdown active
    output logic path_shutdown // path thermal trip active
);
    import spsc_pkg::*;

    // ****************************************
    // boot and strap decode
    // ****************************************
    spsc_boot_type boot_r, boot_nxt;
    logic hv_r, hv_nxt, loaded_r, loaded_nxt;
    logic [1:0] idx_r, idx_nxt;
    logic strap_hit;
    logic [1:0] strap_idx;
    logic strap_hv;

    always_comb
    begin
        strap_hit = 1'b1;
        strap_hv = 1'b1;
        strap_idx = `SPSC_IDX1;
        case ({strap_in_a, strap_in_b})
            {`SPSC_HV1_A, `SPSC_HV1_B}: strap_idx = `SPSC_IDX1;
            {`SPSC_HV2_A, `SPSC_HV2_B}: strap_idx = `SPSC_IDX2;
            {`SPSC_HV3_A, `SPSC_HV3_B}: strap_idx = `SPSC_IDX3;
            {`SPSC_HV4_A, `SPSC_HV4_B}: strap_idx = `SPSC_IDX4;
            {`SPSC_SF1_A, `SPSC_SF1_B}: {strap_hv, strap_idx} = {1'b0, `SPSC_IDX1};
            {`SPSC_SF2_A, `SPSC_SF2_B}: {strap_hv, strap_idx} = {1'b0, `SPSC_IDX2};
            {`SPSC_SF3_A, `SPSC_SF3_B}: {strap_hv, strap_idx} = {1'b0, `SPSC_IDX3};
            {`SPSC_SF4_A, `SPSC_SF4_B}: {strap_hv, strap_idx} = {1'b0, `SPSC_IDX4};
            default: {strap_hit, strap_hv} = 2'h0;
        endcase
    end

    always_comb
    begin
        boot_nxt = boot_r;
        hv_nxt = hv_r;
        idx_nxt = idx_r;
        loaded_nxt = loaded_r;
        case (boot_r)
            SPSC_BOOT_STRAP:
            begin
                hv_nxt = strap_hv;
                idx_nxt = strap_idx;
                boot_nxt = SPSC_BOOT_EEPROM;
            end
            SPSC_BOOT_EEPROM:
            begin
                if (!eeprom_present)
                    boot_nxt = SPSC_BOOT_HOST;
                else if (eeprom_done)
                begin
                    loaded_nxt = 1'b1;
                    boot_nxt = SPSC_BOOT_RUN;
                end
            end
            SPSC_BOOT_HOST:
                if (host_cfg_done)
                begin
                    loaded_nxt = 1'b1;
                    boot_nxt = SPSC_BOOT_RUN;
                end
            SPSC_BOOT_RUN: boot_nxt = SPSC_BOOT_RUN;
            default: boot_nxt = SPSC_BOOT_STRAP;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            boot_r <= SPSC_BOOT_STRAP;
            hv_r <= 1'b0;
            idx_r <= `SPSC_IDX1;
            loaded_r <= 1'b0;
        end
        else
        begin
            boot_r <= boot_nxt;
            hv_r <= hv_nxt;
            idx_r <= idx_nxt;
            loaded_r <= loaded_nxt;
        end
    end

    // ****************************************
    // thermal protection
    // ****************************************
    logic die_r, die_nxt, trip_r, trip_nxt;

    always_comb
    begin
        die_nxt = die_r;
        if (die_hot)
            die_nxt = 1'b1;
        else if (die_cool)
            die_nxt = 1'b0;
        trip_nxt = trip_r;
        if (|path_hot)
            trip_nxt = 1'b1;
        else if ((&path_cool) && (path_auto_resume || fw_path_reenable))
            trip_nxt = 1'b0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            die_r <= 1'b0;
            trip_r <= 1'b0;
        end
        else
        begin
            die_r <= die_nxt;
            trip_r <= trip_nxt;
        end
    end

    // ****************************************
    // power state machine
    // ****************************************
    spsc_pwr_type pwr_r, pwr_nxt;
    logic [15:0] quiet_r, quiet_nxt;
    logic activity;

    assign activity = pd_msg_evt | cc_change_evt | gpio_evt | i2c_evt | volt_alert
        | fault_alert;

    always_comb
    begin
        pwr_nxt = pwr_r;
        quiet_nxt = `SPSC_CNT_ZERO;
        case (pwr_r)
            SPSC_PWR_ACTIVE:
            begin
                if (!activity)
                    quiet_nxt = quiet_r + `SPSC_CNT_ONE;
                if (!activity && (quiet_r + `SPSC_CNT_ONE >= idle_timeout))
                begin
                    pwr_nxt = SPSC_PWR_IDLE;
                    quiet_nxt = `SPSC_CNT_ZERO;
                end
            end
            SPSC_PWR_IDLE:
                if (activity)
                    pwr_nxt = SPSC_PWR_ACTIVE;
                else if (!attached)
                    pwr_nxt = SPSC_PWR_SLEEP;
            SPSC_PWR_SLEEP:
                if (attached || activity)
                    pwr_nxt = SPSC_PWR_ACTIVE;
            default: pwr_nxt = SPSC_PWR_ACTIVE;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pwr_r <= SPSC_PWR_ACTIVE;
            quiet_r <= `SPSC_CNT_ZERO;
        end
        else
        begin
            pwr_r <= pwr_nxt;
            quiet_r <= quiet_nxt;
        end
    end

    // ****************************************
    // output registers
    // ****************************************
    logic run_ok, stby, sink_ok, sink_on, src_on, cab_on, app_on;

    always_comb
    begin
        run_ok = !die_r && (boot_r == SPSC_BOOT_RUN || hv_r) && boot_r != SPSC_BOOT_STRAP;
        app_on = !die_r && boot_r != SPSC_BOOT_STRAP && (hv_r || loaded_r);
        stby = pwr_r == SPSC_PWR_IDLE && standby_req;
        sink_ok = hv_r || loaded_r;
        src_on = run_ok && !trip_r && role_source && pwr_r != SPSC_PWR_SLEEP;
        sink_on = run_ok && sink_ok && !role_source && attached && !stby
            && pwr_r != SPSC_PWR_SLEEP;
        cab_on = run_ok && !trip_r && !stby && pwr_r != SPSC_PWR_SLEEP;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            policy_hv_negotiate <= 1'b0;
            policy_safe <= 1'b0;
            addr_index <= `SPSC_IDX1;
            i2c_target_addr <= `SPSC_ADDR_BASE;
            eeprom_load_req <= 1'b0;
            cfg_loaded <= 1'b0;
            application_mode <= 1'b0;
            pd_phy_en <= 1'b0;
            contract_vmax_mv <= `SPSC_CNT_ZERO;
            power_state <= SPSC_PWR_ACTIVE;
            modern_standby <= 1'b0;
            cc_monitor_en <= 1'b0;
            source_5v_path <= 1'b0;
            sink_hv_path <= 1'b0;
            sink_ext_path_ctrl <= 1'b0;
            cable_power_path <= 1'b0;
            die_shutdown <= 1'b0;
            path_shutdown <= 1'b0;
        end
        else
        begin
            policy_hv_negotiate <= hv_r && boot_r != SPSC_BOOT_STRAP;
            policy_safe <= !hv_r && boot_r != SPSC_BOOT_STRAP;
            addr_index <= idx_r;
            i2c_target_addr <= `SPSC_ADDR_BASE + {5'h00, idx_r};
            eeprom_load_req <= boot_r == SPSC_BOOT_EEPROM;
            cfg_loaded <= loaded_r;
            application_mode <= app_on;
            pd_phy_en <= app_on;
            contract_vmax_mv <= hv_r ? `SPSC_VMAX_MV : `SPSC_CNT_ZERO;
            power_state <= pwr_r;
            modern_standby <= stby;
            cc_monitor_en <= !die_r;
            source_5v_path <= src_on;
            sink_hv_path <= sink_on;
            sink_ext_path_ctrl <= sink_on;
            cable_power_path <= cab_on;
            die_shutdown <= die_r;
            path_shutdown <= trip_r;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sequence die_trip_s;
        die_hot ##1 1'b1;
    endsequence
    sequence cool_down_s;
        die_r && !die_hot && die_cool;
    endsequence

    die_off_a: assert property (die_trip_s |=> !source_5v_path && !sink_hv_path
        && !cable_power_path && !pd_phy_en)
        else $error("outputs active during die shutdown");
    die_resume_a: assert property (cool_down_s |=> !die_r)
        else $error("die shutdown did not clear");
    path_trip_a: assert property (|path_hot |=> ##1 !source_5v_path && !cable_power_path)
        else $error("power path not cut on path overtemp");
    path_hold_a: assert property (trip_r && !path_auto_resume && !fw_path_reenable
        && !(|path_hot) |=> trip_r)
        else $error("path resumed without permission");
    sleep_off_a: assert property (power_state == SPSC_PWR_SLEEP |-> !source_5v_path
        && !sink_hv_path && !cable_power_path)
        else $error("path on in sleep");
    sleep_cc_a: assert property (pwr_r == SPSC_PWR_SLEEP && !die_r |=> cc_monitor_en)
        else $error("cc monitor off in sleep");
    stby_cable_a: assert property (modern_standby |-> !cable_power_path && !sink_hv_path)
        else $error("cable or sink on in standby");
    idle_quiet_a: assert property (pwr_r == SPSC_PWR_ACTIVE && activity |=>
        pwr_r == SPSC_PWR_ACTIVE && quiet_r == `SPSC_CNT_ZERO)
        else $error("left active despite activity");
    idle_wake_a: assert property (pwr_r == SPSC_PWR_IDLE && activity |=>
        pwr_r == SPSC_PWR_ACTIVE)
        else $error("idle not woken by activity");
    safe_pd_a: assert property (policy_safe && !cfg_loaded |-> !pd_phy_en)
        else $error("pd enabled before config under safe policy");
    addr_map_a: assert property (boot_r == SPSC_BOOT_RUN |-> ##1
        i2c_target_addr == `SPSC_ADDR_BASE + {5'h00, $past(idx_r)})
        else $error("target address mismatch");
    boot_seq_a: assert property (boot_r == SPSC_BOOT_STRAP |=>
        boot_r == SPSC_BOOT_EEPROM ##1 eeprom_load_req)
        else $error("boot order broken");
    strap_dec_a: assert property (boot_r == SPSC_BOOT_STRAP && strap_hit |=>
        hv_r == $past(strap_hv) && idx_r == $past(strap_idx))
        else $error("strap decode wrong");
endmodule
